//--- rtl/sfr_bank_defines.svh
// register offsets, field positions, reset values and timing counts of the register bank
// assumes inclusion by bare name from rtl/
`ifndef SFR_BANK_DEFINES_SVH
`define SFR_BANK_DEFINES_SVH
`define ADDR_STATUS 6'h03
`define ADDR_RAMSEL 6'h04
`define ADDR_PORT5 6'h05
`define ADDR_PORT9 6'h09
`define ADDR_RXBUF 6'h0A
`define ADDR_TXBUF 6'h0B
`define ADDR_SSTAT 6'h0C
`define ADDR_SCTRL 6'h0D
`define ADDR_T1CNT 6'h0E
`define ADDR_MATCH 6'h0F
`define ADDR_IFLAG 6'h3F
`define ST_ZERO 2
`define ST_PDOWN 3
`define ST_TOUT 4
`define ST_PSL 5
`define ST_PSH 6
`define SS_TM1 4
`define SS_ODD 3
`define SS_ODC 2
`define SS_RX_FULL_IRQ_FLAG 1
`define SS_RBF 0
`define SC_EDGE 7
`define SC_EN 6
`define SC_OVR 5
`define SC_GO 4
`define IF_TICK 0
`define IF_EXT 1
`define IF_SER 2
`define IF_TM1 3
`define PC_PULLDIS 7
`define PC_IRQEN 6
`define PC_TARGET 3
`define RST_STATUS 8'h18
`define RST_PRESCALE 8'h3F
`define RST_DIR 8'hFF
`define PORT9_MASK 8'h3F
`define PC_WMASK 8'h8F
`define IFLAG_MASK 8'h0F
`define SHIFT_HALF 4'h3
`endif

//--- rtl/sfr_bank_pkg.sv
// types shared by the register bank
// assumes the defines header is compiled alongside
package sfr_bank_pkg;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_LOW = 2'b01,
        SER_HIGH = 2'b11
    } ser_state_t;
endpackage : sfr_bank_pkg

//--- rtl/mcu_operational_register_bank.sv
// special-function register bank of an 8-bit controller core
// assumes the core gives one-cycle op strobes and a register port on mclk
`timescale 1ns/1ns
`include "sfr_bank_defines.svh"
// Function
// - zero flag set on zero ALU result
// - power-down flag: set power-on/wdt-clear, sleep clears
// - timeout flag set power/sleep/wdt-clear, timeout clears
// - page-select bits copied to pc bits 11-12
// - returns leave page-select bits untouched
// - upper page bit reads zero, ignores writes
// - ram pointer: index and bank, plain storage
// - port 9 holds six bits, top zero
// - tx buffer holds byte, rx holds result
// - full byte sets rx-full interrupt flag
// - open-drain selects for data and clock outputs
// - edge select swaps shift and sample edges
// - slave overrun sets overflow, data corrupted
// - shift-go starts byte, hardware clears after
// - timer1 counts to match preset, then zero
// - four event sources set flags, software clears
// - writes to flags only clear them
// - flag read returns flags AND mask
// - pull-up disable bit gates port pull-ups
// - global irq enable only by op strobes
// - prescaler target and doubling ratio field
// - direction bit one means input
module mcu_operational_register_bank (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] dir_sel,
    input wire logic dir_wr,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] prescale_control,
    output logic [39:0] port_direction,
    input wire logic alu_valid,
    input wire logic [7:0] alu_result,
    input wire logic watchdog_clear_op,
    input wire logic sleep_op,
    input wire logic watchdog_timeout,
    input wire logic pc_load_op,
    input wire logic return_op,
    input wire logic irq_disable_op,
    input wire logic irq_enable_op,
    input wire logic return_irq_op,
    output logic [1:0] pc_page,
    output logic [7:0] ram_bank_pointer,
    output logic [39:0] port_out,
    input wire logic [39:0] port_in,
    output logic pullup_enable,
    input wire logic tick_overflow,
    input wire logic ext_irq_n,
    input wire logic timer1_enable,
    input wire logic timer1_tick,
    input wire logic [3:0] irq_mask_reg,
    output logic irq_request,
    input wire logic slave_mode,
    input wire logic ser_clk_in,
    input wire logic ser_din,
    output logic ser_clk_out,
    output logic ser_clk_oe,
    output logic ser_dout,
    output logic ser_dout_oe
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic hit(input logic [5:0] a);
        hit = reg_wr && (reg_addr == a);
    endfunction : hit

    logic [7:0] status;
    logic [7:0] serial_tx_buffer;
    logic [7:0] serial_rx_buffer;
    logic [7:0] serial_state_reg;
    logic [7:0] serial_config_reg;
    logic [7:0] timer1_count;
    logic [7:0] match_preset;
    logic [3:0] irq_flags;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt;
    logic [3:0] div_cnt;
    logic byte_done;
    logic ext_prev;
    logic clk_prev;
    logic t1_match;
    sfr_bank_pkg::ser_state_t ser_state;

    // ************************************************************
    // processor status
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status <= `RST_STATUS;
        end else begin
            if (hit(`ADDR_STATUS)) begin
                status <= {reg_wdata[7], 1'b0, reg_wdata[5], status[4:3], reg_wdata[2:0]};
            end
            if (alu_valid) begin
                status[`ST_ZERO] <= (alu_result == 8'h00);
            end
            if (sleep_op) begin
                status[`ST_PDOWN] <= 1'b0;
                status[`ST_TOUT] <= 1'b1;
            end
            if (watchdog_clear_op) begin
                status[`ST_PDOWN] <= 1'b1;
                status[`ST_TOUT] <= 1'b1;
            end
            if (watchdog_timeout) begin
                status[`ST_TOUT] <= 1'b0;
            end
        end
    end

    // page only follows explicit pc loads; returns use the stacked page
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_page <= 2'b00;
        end else if (pc_load_op && !return_op) begin
            pc_page <= {1'b0, status[`ST_PSL]};
        end
    end

    // ************************************************************
    // ram pointer, ports, directions, control
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ram_bank_pointer <= 8'h00;
        end else if (hit(`ADDR_RAMSEL)) begin
            ram_bank_pointer <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_out <= 40'h00_0000_0000;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (hit(`ADDR_PORT5 + 6'(i))) begin
                    port_out[i*8 +: 8] <= (i == 4) ? (reg_wdata & `PORT9_MASK) : reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_direction <= {5{`RST_DIR}};
        end else if (dir_wr && dir_sel < 3'h5) begin
            port_direction[dir_sel*8 +: 8] <= (dir_sel == 3'h4) ? (ctrl_wdata | ~`PORT9_MASK) : ctrl_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_control <= `RST_PRESCALE;
        end else begin
            if (ctrl_wr) begin
                prescale_control[7] <= ctrl_wdata[7];
                prescale_control[3:0] <= ctrl_wdata[3:0];
            end
            if (irq_disable_op) begin
                prescale_control[`PC_IRQEN] <= 1'b0;
            end else if (irq_enable_op || return_irq_op) begin
                prescale_control[`PC_IRQEN] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_enable <= 1'b0;
        end else begin
            pullup_enable <= !prescale_control[`PC_PULLDIS];
        end
    end

    // ************************************************************
    // timer1
    // ************************************************************
    assign t1_match = timer1_enable && timer1_tick && (timer1_count == match_preset);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer1_count <= 8'h00;
            match_preset <= 8'hFF;
        end else begin
            if (hit(`ADDR_MATCH)) begin
                match_preset <= reg_wdata;
            end
            if (hit(`ADDR_T1CNT)) begin
                timer1_count <= reg_wdata;
            end else if (t1_match) begin
                timer1_count <= 8'h00;
            end else if (timer1_enable && timer1_tick) begin
                timer1_count <= timer1_count + 8'h01;
            end
        end
    end

    // ************************************************************
    // serial shift engine
    // ************************************************************
    logic shift_edge;
    logic sample_edge;
    always_comb begin
        shift_edge = 1'b0;
        sample_edge = 1'b0;
        if (slave_mode) begin
            shift_edge = serial_config_reg[`SC_EDGE] ? (clk_prev && !ser_clk_in) : (!clk_prev && ser_clk_in);
            sample_edge = serial_config_reg[`SC_EDGE] ? (!clk_prev && ser_clk_in) : (clk_prev && !ser_clk_in);
        end else if (div_cnt == `SHIFT_HALF) begin
            shift_edge = (ser_state == sfr_bank_pkg::SER_LOW);
            sample_edge = (ser_state == sfr_bank_pkg::SER_HIGH);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_state <= sfr_bank_pkg::SER_IDLE;
            shift_reg <= 8'h00;
            bit_cnt <= 3'h0;
            div_cnt <= 4'h0;
            clk_prev <= 1'b0;
            byte_done <= 1'b0;
        end else begin
            clk_prev <= ser_clk_in;
            byte_done <= 1'b0;
            div_cnt <= (div_cnt == `SHIFT_HALF) ? 4'h0 : div_cnt + 4'h1;
            case (ser_state)
                sfr_bank_pkg::SER_IDLE: begin
                    div_cnt <= 4'h0;
                    if (serial_config_reg[`SC_GO] && serial_config_reg[`SC_EN] && !byte_done) begin
                        shift_reg <= serial_tx_buffer;
                        bit_cnt <= 3'h0;
                        ser_state <= sfr_bank_pkg::SER_LOW;
                    end
                end
                sfr_bank_pkg::SER_LOW: begin
                    if (shift_edge) begin
                        ser_state <= sfr_bank_pkg::SER_HIGH;
                    end
                end
                sfr_bank_pkg::SER_HIGH: begin
                    if (sample_edge) begin
                        shift_reg <= {shift_reg[6:0], ser_din};
                        ser_state <= sfr_bank_pkg::SER_LOW;
                        if (bit_cnt == 3'h7) begin
                            byte_done <= 1'b1;
                            ser_state <= sfr_bank_pkg::SER_IDLE;
                        end
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                end
                default: ser_state <= sfr_bank_pkg::SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serial_tx_buffer <= 8'h00;
            serial_rx_buffer <= 8'h00;
            serial_config_reg <= 8'h00;
            serial_state_reg <= 8'h00;
        end else begin
            if (hit(`ADDR_TXBUF)) begin
                serial_tx_buffer <= reg_wdata;
            end
            if (hit(`ADDR_SCTRL)) begin
                serial_config_reg <= {reg_wdata[7:5], reg_wdata[4] | serial_config_reg[4], 1'b0, reg_wdata[2:0]};
            end
            if (hit(`ADDR_SSTAT)) begin
                serial_state_reg <= {3'b000, reg_wdata[4:0]};
            end
            if (!reg_wr && reg_addr == `ADDR_RXBUF) begin
                serial_state_reg[`SS_RBF] <= 1'b0;
            end
            if (t1_match) begin
                serial_state_reg[`SS_TM1] <= 1'b1;
            end
            if (byte_done) begin
                serial_rx_buffer <= shift_reg;
                serial_state_reg[`SS_RBF] <= 1'b1;
                serial_state_reg[`SS_RX_FULL_IRQ_FLAG] <= 1'b1;
                serial_config_reg[`SC_GO] <= 1'b0;
                if (slave_mode && serial_state_reg[`SS_RBF]) begin
                    serial_config_reg[`SC_OVR] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_clk_out <= 1'b0;
            ser_clk_oe <= 1'b0;
            ser_dout <= 1'b0;
            ser_dout_oe <= 1'b0;
        end else begin
            ser_clk_out <= (ser_state == sfr_bank_pkg::SER_HIGH) ^ serial_config_reg[`SC_EDGE];
            ser_dout <= (ser_state == sfr_bank_pkg::SER_HIGH) ? shift_reg[7] : ser_dout;
            // open-drain: drive only the low level
            ser_clk_oe <= serial_config_reg[`SC_EN] && !slave_mode && (!serial_state_reg[`SS_ODC]
                || ((ser_state == sfr_bank_pkg::SER_HIGH) == serial_config_reg[`SC_EDGE]));
            ser_dout_oe <= serial_config_reg[`SC_EN]
                && (!serial_state_reg[`SS_ODD] || !((ser_state == sfr_bank_pkg::SER_HIGH) ? shift_reg[7] : ser_dout));
        end
    end

    // ************************************************************
    // interrupt flags
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags <= 4'h0;
            ext_prev <= 1'b1;
            irq_request <= 1'b0;
        end else begin
            ext_prev <= ext_irq_n;
            // set beats clear in the same cycle
            irq_flags <= (hit(`ADDR_IFLAG) ? (irq_flags & reg_wdata[3:0]) : irq_flags)
                | {t1_match, byte_done, ext_prev && !ext_irq_n, tick_overflow};
            irq_request <= prescale_control[`PC_IRQEN] && |(irq_flags & irq_mask_reg);
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `ADDR_STATUS: reg_rdata <= status;
                `ADDR_RAMSEL: reg_rdata <= ram_bank_pointer;
                6'h05, 6'h06, 6'h07, 6'h08: reg_rdata <= port_in[(reg_addr - `ADDR_PORT5)*8 +: 8];
                `ADDR_PORT9: reg_rdata <= port_in[39:32] & `PORT9_MASK;
                `ADDR_RXBUF: reg_rdata <= serial_rx_buffer;
                `ADDR_TXBUF: reg_rdata <= serial_tx_buffer;
                `ADDR_SSTAT: reg_rdata <= serial_state_reg;
                `ADDR_SCTRL: reg_rdata <= serial_config_reg;
                `ADDR_T1CNT: reg_rdata <= timer1_count;
                `ADDR_MATCH: reg_rdata <= match_preset;
                `ADDR_IFLAG: reg_rdata <= {4'h0, irq_flags & irq_mask_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        alu_valid && !sleep_op |=> status[`ST_ZERO] == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
    a_sleep_pdown: assert property (@(posedge mclk) disable iff (!rst_n)
        sleep_op && !watchdog_clear_op |=> !status[`ST_PDOWN])
        else $error("power-down flag not cleared");
    a_tout_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        watchdog_timeout |=> !status[`ST_TOUT])
        else $error("timeout flag not cleared");
    a_page_high: assert property (@(posedge mclk) disable iff (!rst_n)
        !status[`ST_PSH] && !pc_page[1])
        else $error("upper page bit set");
    a_t1_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        t1_match && !hit(`ADDR_T1CNT) |=> timer1_count == 8'h00 ##0 irq_flags[`IF_TM1])
        else $error("timer1 did not wrap");
    a_flag_noset: assert property (@(posedge mclk) disable iff (!rst_n)
        hit(`ADDR_IFLAG) && !t1_match && !byte_done && !tick_overflow && !(ext_prev && !ext_irq_n)
        |=> (irq_flags & ~$past(irq_flags)) == 4'h0)
        else $error("write set a flag");
    a_go_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        byte_done && !hit(`ADDR_SCTRL) |=> !serial_config_reg[`SC_GO] ##0 serial_state_reg[`SS_RX_FULL_IRQ_FLAG])
        else $error("shift-go not cleared");
    a_irq_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_disable_op |=> !prescale_control[`PC_IRQEN])
        else $error("irq enable not cleared");
endmodule : mcu_operational_register_bank

//--- verification/tb_mcu_operational_register_bank.sv
// self-checking bench for the special-function register bank
// assumes the bank alone, driven at the falling edge of mclk, no far-side model
`timescale 1ns/1ns
module tb_mcu_operational_register_bank;
    // ****************************************
    // stimulus and observation signals
    // ****************************************
    typedef struct {
        logic [3:0] kind;
        logic [2:0] sel;
        logic [7:0] want;
        logic [7:0] mask;
    } note_t;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic [5:0] reg_addr = 6'h00;
    logic reg_wr = 1'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] dir_sel = 3'h0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [7:0] alu_result = 8'h00;
    logic [12:0] ops = 13'h0000;
    logic [39:0] port_in = 40'h0000000000;
    logic ext_irq_n = 1'h1;
    logic timer1_enable = 1'h0;
    logic [3:0] irq_mask_reg = 4'hF;
    logic slave_mode = 1'h0;
    logic ser_clk_in = 1'h0;
    logic ser_din = 1'h0;
    logic look = 1'h0;
    logic [7:0] reg_rdata;
    logic [7:0] prescale_control;
    logic [39:0] port_direction;
    logic [1:0] pc_page;
    logic [7:0] ram_bank_pointer;
    logic [39:0] port_out;
    logic pullup_enable;
    logic irq_request;
    logic ser_clk_out;
    logic ser_clk_oe;
    logic ser_dout;
    logic ser_dout_oe;
    note_t notes[$];
    note_t nm;
    logic [7:0] got;
    logic [31:0] r;
    logic [7:0] pc;
    logic [7:0] w;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] cap;
    int err_total = 0;
    int samples_checked = 0;
    int i;
    int k;
    int ns;

    always #25 mclk = ~mclk;

    mcu_operational_register_bank i_mcu_operational_register_bank (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .dir_sel(dir_sel), .dir_wr(ops[10]), .ctrl_wr(ops[11]),
        .ctrl_wdata(ctrl_wdata), .prescale_control(prescale_control), .port_direction(port_direction),
        .alu_valid(ops[12]), .alu_result(alu_result), .watchdog_clear_op(ops[0]), .sleep_op(ops[1]),
        .watchdog_timeout(ops[2]), .pc_load_op(ops[3]), .return_op(ops[4]), .irq_disable_op(ops[5]),
        .irq_enable_op(ops[6]), .return_irq_op(ops[7]), .pc_page(pc_page),
        .ram_bank_pointer(ram_bank_pointer), .port_out(port_out), .port_in(port_in),
        .pullup_enable(pullup_enable), .tick_overflow(ops[8]), .ext_irq_n(ext_irq_n),
        .timer1_enable(timer1_enable), .timer1_tick(ops[9]), .irq_mask_reg(irq_mask_reg),
        .irq_request(irq_request), .slave_mode(slave_mode), .ser_clk_in(ser_clk_in), .ser_din(ser_din),
        .ser_clk_out(ser_clk_out), .ser_clk_oe(ser_clk_oe), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe)
    );

    // ****************************************
    // shared tasks and the result watcher
    // ****************************************
    task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t want=%h got=%h", $time, e, g);
        end
    endtask : check_byte

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // kind 0 reads reg a, other kinds look at a bank output, byte a[2:0]
    task automatic note(input logic [3:0] kd, input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
        note_t nt;
        nt.kind = kd;
        nt.sel = a[2:0];
        nt.want = e;
        nt.mask = m;
        @(negedge mclk);
        if (kd == 4'h0) begin
            reg_addr = a;
        end
        notes.push_back(nt);
        look = 1'h1;
        @(negedge mclk);
        look = 1'h0;
    endtask : note

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge mclk);
        reg_wr = 1'h0;
    endtask : wr

    task automatic op(input logic [12:0] m);
        @(negedge mclk);
        ops = m;
        @(negedge mclk);
        ops = 13'h0000;
    endtask : op

    always @(posedge mclk) begin
        if (look) begin
            #1;
            if (notes.size() == 0) begin
                check_byte(8'h00, 8'hFF);
            end else begin
                nm = notes.pop_front();
                case (nm.kind)
                    4'h0: got = reg_rdata;
                    4'h1: got = {6'h00, pc_page};
                    4'h2: got = {7'h00, irq_request};
                    4'h3: got = {7'h00, pullup_enable};
                    4'h4: got = prescale_control;
                    4'h5: got = port_direction[nm.sel * 8 +: 8];
                    4'h6: got = port_out[nm.sel * 8 +: 8];
                    4'h8: got = {6'h00, ser_clk_oe, ser_dout_oe};
                    default: got = ram_bank_pointer;
                endcase
                check_byte(nm.want & nm.mask, got & nm.mask);
            end
        end
    end

    // a hang anywhere still ends in the single verdict
    initial begin
        repeat (50000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(16));
        port_in = 40'({$urandom, $urandom});
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'h1;
        repeat (3) @(posedge mclk);
        note(4'h0, 6'h03, 8'h18, 8'hFF);
        note(4'h4, 6'h00, 8'h3F, 8'hFF);
        note(4'h5, 6'h04, 8'hFF, 8'hFF);
        note(4'h3, 6'h00, 8'h01, 8'hFF);
        $display("test reset done");
        wr(6'h03, 8'hFF);
        note(4'h0, 6'h03, 8'hBF, 8'hFF);
        wr(6'h03, 8'h00);
        note(4'h0, 6'h03, 8'h18, 8'hFF);
        op(13'h0002);
        note(4'h0, 6'h03, 8'h10, 8'hFF);
        op(13'h0004);
        note(4'h0, 6'h03, 8'h00, 8'hFF);
        op(13'h0001);
        note(4'h0, 6'h03, 8'h18, 8'hFF);
        alu_result = 8'h00;
        op(13'h1000);
        note(4'h0, 6'h03, 8'h1C, 8'hFF);
        r = $urandom;
        alu_result = {1'h1, r[6:0]};
        op(13'h1000);
        note(4'h0, 6'h03, 8'h18, 8'hFF);
        $display("test status done");
        wr(6'h03, 8'h78);
        op(13'h0008);
        note(4'h1, 6'h00, 8'h01, 8'hFF);
        wr(6'h03, 8'h18);
        op(13'h0018);
        note(4'h1, 6'h00, 8'h01, 8'hFF);
        note(4'h0, 6'h03, 8'h18, 8'hFF);
        op(13'h0008);
        note(4'h1, 6'h00, 8'h00, 8'hFF);
        $display("test page done");
        r = $urandom;
        wr(6'h04, r[7:0]);
        note(4'h0, 6'h04, r[7:0], 8'hFF);
        note(4'h7, 6'h00, r[7:0], 8'hFF);
        wr(6'h09, 8'hFF);
        note(4'h6, 6'h04, 8'h3F, 8'hFF);
        wr(6'h05, r[15:8]);
        note(4'h6, 6'h00, r[15:8], 8'hFF);
        note(4'h0, 6'h09, {2'h0, port_in[37:32]}, 8'hFF);
        ctrl_wdata = 8'h00;
        dir_sel = 3'h4;
        op(13'h0400);
        note(4'h5, 6'h04, 8'hC0, 8'hFF);
        ctrl_wdata = r[23:16];
        dir_sel = 3'h0;
        op(13'h0400);
        note(4'h5, 6'h00, r[23:16], 8'hFF);
        $display("test ports done");
        pc = 8'h3F;
        for (i = 0; i < 8; i++) begin
            w = 8'($urandom);
            w[2:0] = i[2:0];
            ctrl_wdata = w;
            op(13'h0800);
            pc = (pc & 8'h70) | (w & 8'h8F);
            note(4'h4, 6'h00, pc, 8'hFF);
            note(4'h3, 6'h00, {7'h00, ~pc[7]}, 8'hFF);
        end
        op(13'h0040);
        note(4'h4, 6'h00, pc | 8'h40, 8'hFF);
        op(13'h0020);
        note(4'h4, 6'h00, pc, 8'hFF);
        op(13'h0080);
        note(4'h4, 6'h00, pc | 8'h40, 8'hFF);
        $display("test control done");
        wr(6'h3F, 8'h00);
        op(13'h0100);
        note(4'h0, 6'h3F, 8'h01, 8'hFF);
        ext_irq_n = 1'h0;
        repeat (3) @(negedge mclk);
        note(4'h0, 6'h3F, 8'h03, 8'hFF);
        note(4'h2, 6'h00, 8'h01, 8'hFF);
        irq_mask_reg = 4'h2;
        note(4'h0, 6'h3F, 8'h02, 8'hFF);
        irq_mask_reg = 4'h0;
        repeat (2) @(negedge mclk);
        note(4'h2, 6'h00, 8'h00, 8'hFF);
        irq_mask_reg = 4'hF;
        wr(6'h3F, 8'hFF);
        note(4'h0, 6'h3F, 8'h03, 8'hFF);
        wr(6'h3F, 8'hFE);
        note(4'h0, 6'h3F, 8'h02, 8'hFF);
        ext_irq_n = 1'h1;
        wr(6'h3F, 8'h00);
        note(4'h0, 6'h3F, 8'h00, 8'hFF);
        $display("test flags done");
        wr(6'h0F, 8'h03);
        note(4'h0, 6'h0F, 8'h03, 8'hFF);
        wr(6'h0E, 8'h00);
        timer1_enable = 1'h1;
        repeat (2) op(13'h0200);
        note(4'h0, 6'h0E, 8'h02, 8'hFF);
        repeat (4) op(13'h0200);
        note(4'h0, 6'h3F, 8'h08, 8'h08);
        timer1_enable = 1'h0;
        wr(6'h3F, 8'h00);
        $display("test timer done");
        // out edge when the clock leaves the edge-select level, sample edge on return
        for (i = 0; i < 2; i++) begin
            tx = 8'($urandom);
            rx = 8'($urandom);
            ser_din = rx[7];
            wr(6'h0B, tx);
            wr(6'h0D, {i[0], 7'h50});
            ns = 0;
            k = 0;
            w[0] = i[0];
            while (ns < 8 && k < 400) begin
                @(negedge mclk);
                k++;
                if (ser_clk_out !== w[0]) begin
                    w[0] = ser_clk_out;
                    if (ser_clk_out !== i[0]) begin
                        ser_din = rx[7 - ns];
                    end else begin
                        cap = {cap[6:0], ser_dout};
                        ns++;
                    end
                end
            end
            if (k >= 400) begin
                err_total++;
                report_and_stop();
            end
            check_byte(tx, cap);
            repeat (4) @(negedge mclk);
            note(4'h0, 6'h0D, {i[0], 7'h40}, 8'hF0);
            note(4'h0, 6'h0C, 8'h03, 8'h03);
            note(4'h0, 6'h3F, 8'h04, 8'h04);
            note(4'h0, 6'h0A, rx, 8'hFF);
            note(4'h0, 6'h0C, 8'h00, 8'h01);
        end
        note(4'h8, 6'h00, 8'h03, 8'hFF);
        wr(6'h0C, 8'h0C);
        note(4'h0, 6'h0C, 8'h0C, 8'h0F);
        note(4'h8, 6'h00, 8'h00, 8'h02);
        $display("test master done");
        // two unread slave bytes in a row must flag an overrun
        slave_mode = 1'h1;
        for (i = 0; i < 2; i++) begin
            wr(6'h0D, 8'h50);
            repeat (8) begin
                repeat (4) @(negedge mclk);
                ser_din = 1'($urandom);
                ser_clk_in = 1'h1;
                repeat (4) @(negedge mclk);
                ser_clk_in = 1'h0;
            end
            repeat (4) @(negedge mclk);
        end
        note(4'h0, 6'h0D, 8'h20, 8'h20);
        $display("test slave done");
        report_and_stop();
    end
endmodule : tb_mcu_operational_register_bank
